// ===== codec_seq_pkg.sv
// Constants and types shared by the volume, mute and power sequencing block
package codec_seq_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ZGRP = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_ATT_BASE = 8'h20;
  localparam int NUM_CH = 8;
  // Control field positions
  localparam int CTRL_RST_N = 0;
  localparam int CTRL_REF = 1;
  localparam int CTRL_INCONV = 2;
  localparam int CTRL_OUTCONV = 3;
  localparam int CTRL_INPAIR_LO = 4;
  localparam int CTRL_OUTPAIR_LO = 6;
  localparam int CTRL_MUTE = 10;
  localparam int CTRL_SPEED_LO = 11;
  localparam logic [12:0] CTRL_RESET = 13'h03FF;
  localparam logic [15:0] ZGRP_RESET = 16'h00FF;
  localparam logic [7:0] ATT_RESET = 8'h00;
  localparam logic [7:0] ATT_MUTE_CODE = 8'hFF;
  // Attenuation level, 16 fine steps per code; full mute sits at 4096
  localparam logic [12:0] LEVEL_MUTE = 13'h1000;
  localparam logic [12:0] RAMP_FRAMES0 = 13'h1000;
  localparam logic [12:0] RAMP_FRAMES1 = 13'h0800;
  localparam logic [12:0] RAMP_FRAMES2 = 13'h0200;
  localparam logic [12:0] RAMP_FRAMES3 = 13'h0100;
  // Sequencing delays, in frame periods
  localparam logic [9:0] START_DLY = 10'h003;
  localparam logic [9:0] STOP_DLY = 10'h004;
  localparam logic [9:0] INIT_IN = 10'h206;
  localparam logic [9:0] INIT_OUT = 10'h204;
  localparam logic [3:0] ZF_RELEASE = 4'h8;
  localparam logic [2:0] DUMMY_GAP = 3'h5;
  localparam logic [13:0] ZERO_FRAMES = 14'h2000;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {SEQ_OFF, SEQ_WAKE, SEQ_INIT, SEQ_RUN, SEQ_SLEEP} seq_e;

  typedef struct packed {
    seq_e st;
    logic [9:0] cnt;
  } seq_s;
endpackage : codec_seq_pkg

// ===== codec_volume_mute_power_sequencer.sv
// Volume ramp, soft mute, zero flags and power sequencing with an AXI4-Lite slave
// Function
// R1: Each of eight channels has its own 8-bit attenuation code, 0.5dB steps.
// R2: Two-bit ramp speed picks 4096, 2048, 512 or 256 frames per full swing.
// R3: Slowest speed walks 4096 fine levels, 00H to FFH in 4096 frames.
// R4: Faster speeds also ramp in steps, never jump.
// R5: Power-down pin low resets every attenuation code to 00H.
// R6: Soft reset low holds attenuation at 00H; release ramps back to programmed level.
// R7: Two-wire mode: power release needs a rewrite 5+ frames later, else 0dB held.
// R8: Soft mute set ramps each channel to full mute at the ramp speed.
// R9: Soft mute cleared, even mid-fade, ramps back at the same rate.
// R10: Zero flag rises after 8192 all-zero frames, drops at any nonzero sample.
// R11: Host pulses the power-down pin low once at power-up.
// R12: Stay down until master and frame clocks exist; timing starts on frame edge.
// R13: Power-down pin low powers down converters and restores register defaults.
// R14: Pin power-down: serial out and zero flags low, outputs parked per park pin.
// R15: Input side starts 518-frame init 3 frames after release; data valid after 521.
// R16: Output side starts 516-frame init 3 frames after release, parked meanwhile.
// R17: With reference power on, block and pair power bits act, registers kept.
// R18: Input power bit low drives serial outputs low.
// R19: Output power bit low forces zero flags high and parks outputs per pin.
// R20: Block power-down follows 4 frames after clear; init starts 3 after set.
// R21: Soft reset low: converters down, outputs mid-rail, flags high, serial low.
// R22: Internal reset 4 frames after soft reset clear; init 3 frames after set.
// R23: Zero flags go low 8 frames after soft reset returns high.
// R24: Applied attenuation is code times 0.5dB, FFH mute; delays count frames.
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module codec_volume_mute_power_sequencer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic power_down_pin_n,
  input wire logic output_park_select,
  input wire logic two_wire_mode,
  input wire logic master_clock_present,
  input wire logic frame_clock,
  input wire logic [7:0] channel_nonzero,
  output logic [63:0] applied_atten_code,
  output logic serial_audio_out_enable,
  output logic [1:0] input_pair_active,
  output logic [3:0] analog_out_active,
  output logic [3:0] analog_out_hiz,
  output logic zero_flag_group1,
  output logic zero_flag_group2
);

  typedef struct packed {
    logic fclk_prev;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [12:0] ctrl;
    logic [15:0] zgrp;
    logic [7:0][7:0] att;
    logic [7:0][12:0] level;
    logic [7:0][7:0] applied;
    codec_seq_pkg::seq_s in_seq;
    codec_seq_pkg::seq_s out_seq;
    logic [3:0] zf_hold;
    logic [13:0] zcnt1;
    logic [13:0] zcnt2;
    logic zf1;
    logic zf2;
    logic dummy_pend;
    logic [2:0] dummy_cnt;
  } state_s;

  state_s q;
  state_s d;

  // Power sequencer step: wake delay, init count, run, delayed power-down
  function automatic codec_seq_pkg::seq_s seq_step(codec_seq_pkg::seq_s s, logic en,
                                                   logic tick, logic [9:0] init_len);
    codec_seq_pkg::seq_s n;
    n = s;
    case (s.st)
      codec_seq_pkg::SEQ_OFF:
      begin
        if (en)
        begin
          n.st = codec_seq_pkg::SEQ_WAKE;
          n.cnt = '0;
        end
      end
      codec_seq_pkg::SEQ_WAKE:
      begin
        if (!en)
          n.st = codec_seq_pkg::SEQ_OFF;
        else if (tick && s.cnt == codec_seq_pkg::START_DLY - 10'h001)
        begin
          n.st = codec_seq_pkg::SEQ_INIT;
          n.cnt = '0;
        end
        else if (tick)
          n.cnt = s.cnt + 10'h001;
      end
      codec_seq_pkg::SEQ_INIT:
      begin
        if (!en)
        begin
          n.st = codec_seq_pkg::SEQ_SLEEP;
          n.cnt = '0;
        end
        else if (tick && s.cnt == init_len - 10'h001)
          n.st = codec_seq_pkg::SEQ_RUN;
        else if (tick)
          n.cnt = s.cnt + 10'h001;
      end
      codec_seq_pkg::SEQ_RUN:
      begin
        if (!en)
        begin
          n.st = codec_seq_pkg::SEQ_SLEEP;
          n.cnt = '0;
        end
      end
      codec_seq_pkg::SEQ_SLEEP:
      begin
        if (en)
          n.st = codec_seq_pkg::SEQ_RUN;
        else if (tick && s.cnt == codec_seq_pkg::STOP_DLY - 10'h001)
          n.st = codec_seq_pkg::SEQ_OFF;
        else if (tick)
          n.cnt = s.cnt + 10'h001;
      end
      default:
        n.st = codec_seq_pkg::SEQ_OFF;
    endcase
    return n;
  endfunction : seq_step

  // Fine level target for a code; FFH maps to full mute
  function automatic logic [12:0] code_to_level(logic [7:0] code);
    if (code == codec_seq_pkg::ATT_MUTE_CODE)
      return codec_seq_pkg::LEVEL_MUTE;
    return {1'b0, code, 4'h0};
  endfunction : code_to_level

  // Fine step per frame so a full swing takes the selected ramp time
  function automatic logic [12:0] ramp_step(logic [1:0] speed);
    case (speed)
      2'h0: return codec_seq_pkg::LEVEL_MUTE / codec_seq_pkg::RAMP_FRAMES0;
      2'h1: return codec_seq_pkg::LEVEL_MUTE / codec_seq_pkg::RAMP_FRAMES1;
      2'h2: return codec_seq_pkg::LEVEL_MUTE / codec_seq_pkg::RAMP_FRAMES2;
      default: return codec_seq_pkg::LEVEL_MUTE / codec_seq_pkg::RAMP_FRAMES3;
    endcase
  endfunction : ramp_step

  logic tick;
  logic ramp_busy;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic in_en;
  logic out_en;
  logic rst_bit;
  logic [12:0] step;
  logic [12:0] tgt;
  logic [12:0] diff;
  logic att_hit;
  logic [2:0] att_idx;
  logic raises;

  // Frame clock rising edge drives all frame-based timing
  assign tick = frame_clock && !q.fclk_prev; // R12 R24
  assign s_axi_awready = !q.aw_got && !q.bvalid;
  assign s_axi_wready = !q.w_got && !q.bvalid;
  assign s_axi_arready = !q.rvalid;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign rst_bit = q.ctrl[codec_seq_pkg::CTRL_RST_N];
  assign step = ramp_step(q.ctrl[codec_seq_pkg::CTRL_SPEED_LO +: 2]); // R2

  // Converter enables need the pin, master clock present, reference power, the block power bit and soft reset
  assign in_en = power_down_pin_n && master_clock_present && q.ctrl[codec_seq_pkg::CTRL_REF]
                 && q.ctrl[codec_seq_pkg::CTRL_INCONV] && rst_bit; // R12 R17 R21
  assign out_en = power_down_pin_n && master_clock_present && q.ctrl[codec_seq_pkg::CTRL_REF]
                  && q.ctrl[codec_seq_pkg::CTRL_OUTCONV] && rst_bit; // R12 R17 R21

  // Next-state logic for bus, registers, ramps, sequencers and zero flags
  always_comb
  begin
    logic [31:0] wr;
    logic [12:0] nctrl;
    logic hold_zero;
    logic z1;
    logic z2;
    wr = 32'h0000_0000;
    nctrl = 13'h0000;
    hold_zero = 1'b0;
    z1 = 1'b0;
    z2 = 1'b0;
    tgt = 13'h0000;
    diff = 13'h0000;
    att_hit = 1'b0;
    att_idx = 3'h0;
    raises = 1'b0;
    ramp_busy = 1'b0;
    d = q;
    d.fclk_prev = frame_clock;

    // Write address and data accepted in either order
    if (aw_take)
    begin
      d.aw_got = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (w_take)
    begin
      d.w_got = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready)
      d.bvalid = 1'b0;

    // Dummy-write gap counter runs in frames
    if (tick && q.dummy_cnt != codec_seq_pkg::DUMMY_GAP)
      d.dummy_cnt = q.dummy_cnt + 3'h1; // R7

    // Commit a write once address and data are both held
    if (q.aw_got && q.w_got && !q.bvalid)
    begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = codec_seq_pkg::RESP_OKAY;
      for (int b = 0; b < 4; b++)
        wr[b*8 +: 8] = q.w_strb[b] ? q.w_data[b*8 +: 8] : 8'h00;
      att_hit = q.aw_addr[7:5] == codec_seq_pkg::OFF_ATT_BASE[7:5] && q.aw_addr[1:0] == 2'h0;
      att_idx = q.aw_addr[4:2];
      if (q.aw_addr == codec_seq_pkg::OFF_CTRL)
      begin
        nctrl = q.ctrl;
        if (q.w_strb[0])
          nctrl[7:0] = wr[7:0];
        if (q.w_strb[1])
          nctrl[12:8] = wr[12:8];
        raises = |(nctrl[9:6] & ~q.ctrl[9:6])
                 || (nctrl[codec_seq_pkg::CTRL_REF] && !q.ctrl[codec_seq_pkg::CTRL_REF])
                 || (nctrl[codec_seq_pkg::CTRL_OUTCONV] && !q.ctrl[codec_seq_pkg::CTRL_OUTCONV])
                 || (nctrl[codec_seq_pkg::CTRL_RST_N] && !rst_bit);
        d.ctrl = nctrl; // R17
        // A release of reference, output power, output pair or soft reset bits in two-wire mode arms the hold; a late rewrite clears it
        if (two_wire_mode && raises)
        begin
          d.dummy_pend = 1'b1; // R7
          d.dummy_cnt = 3'h0;
        end
        else if (q.dummy_pend && q.dummy_cnt == codec_seq_pkg::DUMMY_GAP)
          d.dummy_pend = 1'b0; // R7
      end
      else if (q.aw_addr == codec_seq_pkg::OFF_ZGRP)
      begin
        if (q.w_strb[0])
          d.zgrp[7:0] = wr[7:0];
        if (q.w_strb[1])
          d.zgrp[15:8] = wr[15:8];
      end
      else if (att_hit)
      begin
        if (q.w_strb[0])
          d.att[att_idx] = wr[7:0]; // R1
      end
      else if (q.aw_addr != codec_seq_pkg::OFF_STATUS)
        d.bresp = codec_seq_pkg::RESP_SLVERR;
    end

    // Ramp each channel toward its effective target, one step per frame
    hold_zero = !rst_bit || q.dummy_pend; // R6 R7
    for (int c = 0; c < codec_seq_pkg::NUM_CH; c++)
    begin
      if (hold_zero)
        tgt = 13'h0000; // R6 R7
      else if (q.ctrl[codec_seq_pkg::CTRL_MUTE])
        tgt = codec_seq_pkg::LEVEL_MUTE; // R8
      else
        tgt = code_to_level(q.att[c]); // R9 R24
      if (q.level[c] != tgt)
        ramp_busy = 1'b1;
      if (tick && q.level[c] < tgt)
      begin
        diff = tgt - q.level[c];
        d.level[c] = q.level[c] + ((diff < step) ? diff : step); // R3 R4
      end
      else if (tick && q.level[c] > tgt)
      begin
        diff = q.level[c] - tgt;
        d.level[c] = q.level[c] - ((diff < step) ? diff : step); // R4 R9
      end
      d.applied[c] = (d.level[c] == codec_seq_pkg::LEVEL_MUTE) ? codec_seq_pkg::ATT_MUTE_CODE
                     : d.level[c][11:4]; // R24
    end

    // Reads answer one cycle after the address is taken
    if (s_axi_rvalid && s_axi_rready)
      d.rvalid = 1'b0;
    if (ar_take)
    begin
      d.rvalid = 1'b1;
      d.rresp = codec_seq_pkg::RESP_OKAY;
      d.rdata = 32'h0000_0000;
      if (s_axi_araddr == codec_seq_pkg::OFF_CTRL)
        d.rdata = {19'h00000, q.ctrl};
      else if (s_axi_araddr == codec_seq_pkg::OFF_ZGRP)
        d.rdata = {16'h0000, q.zgrp};
      else if (s_axi_araddr == codec_seq_pkg::OFF_STATUS)
        d.rdata = {25'h0000000, master_clock_present, ramp_busy, q.dummy_pend, q.zf2, q.zf1,
                   q.out_seq.st == codec_seq_pkg::SEQ_RUN, q.in_seq.st == codec_seq_pkg::SEQ_RUN};
      else if (s_axi_araddr[7:5] == codec_seq_pkg::OFF_ATT_BASE[7:5]
               && s_axi_araddr[1:0] == 2'h0)
        d.rdata = {24'h000000, q.att[s_axi_araddr[4:2]]};
      else
        d.rresp = codec_seq_pkg::RESP_SLVERR;
    end
    // Block sequencers: start, init count and delayed power-down
    d.in_seq = seq_step(q.in_seq, in_en, tick, codec_seq_pkg::INIT_IN); // R15 R20 R22
    d.out_seq = seq_step(q.out_seq, out_en, tick, codec_seq_pkg::INIT_OUT); // R16 R20 R22

    // Zero flags forced high while output power or soft reset is off, then held
    if (!rst_bit || !q.ctrl[codec_seq_pkg::CTRL_OUTCONV])
      d.zf_hold = codec_seq_pkg::ZF_RELEASE; // R19 R21
    else if (tick && q.zf_hold != 4'h0)
      d.zf_hold = q.zf_hold - 4'h1; // R23
    z1 = |(channel_nonzero & q.zgrp[7:0]);
    z2 = |(channel_nonzero & q.zgrp[15:8]);
    if (d.zf_hold != 4'h0 || z1)
      d.zcnt1 = 14'h0000; // R10
    else if (tick && q.zcnt1 != codec_seq_pkg::ZERO_FRAMES)
      d.zcnt1 = q.zcnt1 + 14'h0001; // R10
    if (d.zf_hold != 4'h0 || z2)
      d.zcnt2 = 14'h0000; // R10
    else if (tick && q.zcnt2 != codec_seq_pkg::ZERO_FRAMES)
      d.zcnt2 = q.zcnt2 + 14'h0001; // R10
    d.zf1 = (d.zf_hold != 4'h0) || (d.zcnt1 == codec_seq_pkg::ZERO_FRAMES); // R10 R19 R23
    d.zf2 = (d.zf_hold != 4'h0) || (d.zcnt2 == codec_seq_pkg::ZERO_FRAMES); // R10 R19 R23

    // Pin power-down restores every control default and stops the converters
    if (!power_down_pin_n)
    begin
      d.ctrl = codec_seq_pkg::CTRL_RESET; // R13
      d.zgrp = codec_seq_pkg::ZGRP_RESET; // R13
      d.att = {codec_seq_pkg::NUM_CH{codec_seq_pkg::ATT_RESET}}; // R5
      d.level = '0; // R5
      d.applied = '0; // R5
      d.in_seq = '{codec_seq_pkg::SEQ_OFF, 10'h000}; // R13
      d.out_seq = '{codec_seq_pkg::SEQ_OFF, 10'h000}; // R13
      d.zf_hold = 4'h0;
      d.zcnt1 = 14'h0000;
      d.zcnt2 = 14'h0000;
      d.zf1 = 1'b0; // R14
      d.zf2 = 1'b0; // R14
      d.dummy_pend = 1'b0;
    end
  end

  // State register with synchronous active-low reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q <= '0;
      q.ctrl <= codec_seq_pkg::CTRL_RESET;
      q.zgrp <= codec_seq_pkg::ZGRP_RESET;
      q.in_seq <= '{codec_seq_pkg::SEQ_OFF, 10'h000};
      q.out_seq <= '{codec_seq_pkg::SEQ_OFF, 10'h000};
    end
    else
      q <= d;
  end

  // Output drive from registered state
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign applied_atten_code = q.applied; // R1
  assign zero_flag_group1 = q.zf1; // R10 R14
  assign zero_flag_group2 = q.zf2; // R10 R14

  // Serial data after init, kept through the delayed power-down
  assign serial_audio_out_enable = q.in_seq.st == codec_seq_pkg::SEQ_RUN
                                   || q.in_seq.st == codec_seq_pkg::SEQ_SLEEP; // R15 R18 R20 R22
  always_comb
  begin
    logic out_up;
    logic force_mid;
    out_up = q.out_seq.st == codec_seq_pkg::SEQ_RUN || q.out_seq.st == codec_seq_pkg::SEQ_SLEEP;
    force_mid = power_down_pin_n && !rst_bit; // R21
    for (int p = 0; p < 2; p++)
      input_pair_active[p] = serial_audio_out_enable
                             && q.ctrl[codec_seq_pkg::CTRL_INPAIR_LO + p]; // R17
    for (int p = 0; p < 4; p++)
    begin
      analog_out_active[p] = out_up && q.ctrl[codec_seq_pkg::CTRL_OUTPAIR_LO + p]; // R16 R17
      analog_out_hiz[p] = !analog_out_active[p] && output_park_select && !force_mid; // R14 R19
    end
  end

endmodule : codec_volume_mute_power_sequencer

// ===== codec_seq_checker_asserts.sv
// Port checker for the volume, mute and power sequencer
`timescale 1ns/1ps
module codec_seq_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic power_down_pin_n,
  input wire logic output_park_select,
  input wire logic frame_clock,
  input wire logic [63:0] applied_atten_code,
  input wire logic serial_audio_out_enable,
  input wire logic [3:0] analog_out_active,
  input wire logic [3:0] analog_out_hiz,
  input wire logic zero_flag_group1,
  input wire logic zero_flag_group2
);
  logic [63:0] prev_q;
  logic [9:0] ticks_q;
  logic fprev_q;
  logic step_ok;

  function automatic logic small_step(input logic [7:0] a, b);
    logic [7:0] d;
    d = a - b;
    return (d == 8'h00) || (d == 8'h01) || (d == 8'hFF);
  endfunction : small_step

  // Last codes, and frame ticks counted since power-down release
  always_ff @(posedge aclk)
  begin
    prev_q <= applied_atten_code;
    fprev_q <= frame_clock;
    if (!aresetn || !power_down_pin_n)
      ticks_q <= 10'h000;
    else if (frame_clock && !fprev_q && ticks_q != 10'h3FF)
      ticks_q <= ticks_q + 10'h001;
  end

  // Each channel may move by one code per clock at most
  always_comb
  begin
    step_ok = 1'b1;
    for (int c = 0; c < 8; c++)
      if (!small_step(applied_atten_code[8*c +: 8], prev_q[8*c +: 8]))
        step_ok = 1'b0;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response not held");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_pin_quiet: assert property (!power_down_pin_n |=>
    !serial_audio_out_enable && !zero_flag_group1 && !zero_flag_group2)
    else $error("outputs not quiet in power-down");
  a_pin_atten: assert property (!power_down_pin_n |=> applied_atten_code == 64'h0)
    else $error("attenuation not cleared");
  a_pin_park: assert property (!power_down_pin_n && !$past(power_down_pin_n) |->
    analog_out_active == 4'h0 && analog_out_hiz == {4{output_park_select}})
    else $error("outputs not parked");
  a_ramp_step: assert property (power_down_pin_n && $past(power_down_pin_n) |-> step_ok)
    else $error("attenuation jumped");
  a_serial_init: assert property ($rose(serial_audio_out_enable) |-> ticks_q >= 10'h209)
    else $error("serial data valid too early");
endmodule : codec_seq_checker

bind codec_volume_mute_power_sequencer codec_seq_checker chk_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .power_down_pin_n(power_down_pin_n), .output_park_select(output_park_select),
  .frame_clock(frame_clock), .applied_atten_code(applied_atten_code),
  .serial_audio_out_enable(serial_audio_out_enable), .analog_out_active(analog_out_active),
  .analog_out_hiz(analog_out_hiz), .zero_flag_group1(zero_flag_group1),
  .zero_flag_group2(zero_flag_group2)
);

// ===== host_clock_source.sv
// Host-side clock source: frame clock and master clock presence
`timescale 1ns/1ps
module host_clock_source (
  input wire logic aclk,
  input wire logic run,
  output logic frame_clock,
  output logic master_clock_present
);
  logic [1:0] div_q;

  // Frame clock is aclk over four and stands still low when stopped
  always_ff @(posedge aclk)
  begin
    if (!run)
      div_q <= 2'h0;
    else
      div_q <= div_q + 2'h1;
  end

  // Both clocks start together, first frame edge rising
  assign frame_clock = div_q[1];
  assign master_clock_present = run;
endmodule : host_clock_source

// ===== tb.sv
// Self-checking bench for the volume, mute and power sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) \
  begin n_fail++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb;
  localparam logic [7:0] CTRL = codec_seq_pkg::OFF_CTRL;
  localparam logic [7:0] ATT0 = codec_seq_pkg::OFF_ATT_BASE;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, nz = 8'hFF;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] wstrb = 4'hF, out_act, hiz;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic pin_n = 1'b0, park = 1'b1, twm = 1'b0, run = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, fclk, mclk, serial, zf1, zf2;
  logic [1:0] bresp, rresp, r, in_act;
  logic [63:0] att;
  int n_fail = 0;
  int checked = 0;
  int tk [4] = '{256, 128, 32, 16};

  codec_volume_mute_power_sequencer codec_volume_mute_power_sequencer_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .power_down_pin_n(pin_n), .output_park_select(park), .two_wire_mode(twm),
    .master_clock_present(mclk), .frame_clock(fclk), .channel_nonzero(nz),
    .applied_atten_code(att), .serial_audio_out_enable(serial), .input_pair_active(in_act),
    .analog_out_active(out_act), .analog_out_hiz(hiz), .zero_flag_group1(zf1),
    .zero_flag_group2(zf2)
  );

  host_clock_source host_clock_source_inst (
    .aclk(aclk), .run(run), .frame_clock(fclk), .master_clock_present(mclk)
  );

  function automatic logic [31:0] ctl(input logic [1:0] s, input logic m, input logic [9:0] lo);
    return {19'h00000, s, m, lo};
  endfunction : ctl

  // Bus write: both halves offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ah = 1'b0, wh = 1'b0, ta, tw, tbv = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ah && wh))
    begin
      @(negedge aclk);
      ta = awready;
      tw = wready;
      @(posedge aclk);
      if (ta && !ah) awvalid <= 1'b0;
      if (tw && !wh) wvalid <= 1'b0;
      ah = ah | ta;
      wh = wh | tw;
    end
    bready <= 1'b1;
    while (!tbv)
    begin
      @(negedge aclk);
      tbv = bvalid;
      r = bresp;
      @(posedge aclk);
    end
    bready <= 1'b0;
  endtask : wr

  // Bus read: address then data, result in d and r
  task automatic rd(input logic [7:0] a);
    logic t = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    while (!t)
    begin
      @(negedge aclk);
      t = arready;
      @(posedge aclk);
    end
    arvalid <= 1'b0;
    rready <= 1'b1;
    t = 1'b0;
    while (!t)
    begin
      @(negedge aclk);
      t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
    end
    rready <= 1'b0;
  endtask : rd

  // Waits n frame ticks, ends on a falling aclk edge
  task automatic wait_fr(input int n);
    repeat (n) @(posedge fclk);
    @(negedge aclk);
  endtask : wait_fr

  task automatic report_and_stop();
    if (n_fail == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  initial forever #50 aclk = ~aclk;

  // Hang guard
  initial
  begin
    repeat (90000) @(posedge aclk);
    n_fail++;
    report_and_stop();
  end

  // Main sequence
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(negedge aclk);
    `CHK("zf1 pd", 1'b0, zf1);
    `CHK("hiz pd", 4'hF, hiz);
    @(posedge aclk);
    pin_n <= 1'b1;
    repeat (200) @(negedge aclk);
    `CHK("ser noclk", 1'b0, serial);
    rd(CTRL);
    `CHK("ctrl rst", 32'h3FF, d);
    rd(codec_seq_pkg::OFF_ZGRP);
    `CHK("zgrp rst", 32'hFF, d);
    rd(ATT0 + 8'h04);
    `CHK("att rst", 32'h0, d);
    rd(8'h40);
    `CHK("unmapped", codec_seq_pkg::RESP_SLVERR, r);
    run <= 1'b1;
    wait_fr(517);
    `CHK("ser init", 1'b0, serial);
    `CHK("hiz init", 4'hF, hiz);
    wait_fr(7);
    `CHK("ser run", 1'b1, serial);
    `CHK("out run", 4'hF, out_act);
    for (int s = 0; s < 4; s++)
    begin
      wr(CTRL, ctl(2'(s), 1'b0, 10'h3FF));
      wr(ATT0, 32'h10);
      wait_fr(tk[s] / 2);
      `CHK("ramp mid", 1'b1, att[7:0] > 8'h00 && att[7:0] < 8'h10);
      wait_fr(tk[s] / 2 + 3);
      `CHK("ramp end", 8'h10, att[7:0]);
      wr(ATT0, 32'h0);
      wait_fr(tk[s] + 3);
      `CHK("ramp back", 8'h00, att[7:0]);
    end
    wr(ATT0 + 8'h1C, 32'hFF);
    wait_fr(260);
    `CHK("ch7", 8'hFF, att[63:56]);
    `CHK("ch0", 8'h00, att[7:0]);
    wr(ATT0, 32'h20);
    wait_fr(40);
    wr(CTRL, ctl(2'h3, 1'b1, 10'h3FF));
    wait_fr(100);
    `CHK("mute mid", 1'b1, att[7:0] > 8'h70 && att[7:0] < 8'h98);
    wr(CTRL, ctl(2'h3, 1'b0, 10'h3FF));
    wait_fr(110);
    `CHK("unmute", 8'h20, att[7:0]);
    wr(ATT0, 32'h0);
    wait_fr(40);
    wr(CTRL, ctl(2'h0, 1'b1, 10'h3FF));
    wait_fr(4000);
    `CHK("slow mid", 1'b1, att[7:0] !== 8'hFF);
    wait_fr(100);
    `CHK("slow end", 8'hFF, att[7:0]);
    wr(CTRL, ctl(2'h3, 1'b0, 10'h3FF));
    wr(ATT0, 32'h20);
    wait_fr(260);
    wr(CTRL, ctl(2'h3, 1'b0, 10'h3FE));
    wait_fr(3);
    `CHK("ser hold", 1'b1, serial);
    wait_fr(3);
    `CHK("zf1 rst", 1'b1, zf1);
    `CHK("zf2 rst", 1'b1, zf2);
    `CHK("ser rst", 1'b0, serial);
    `CHK("mid rst", 4'h0, out_act | hiz);
    wait_fr(40);
    `CHK("att rst0", 8'h00, att[7:0]);
    rd(CTRL);
    `CHK("ctrl kept", ctl(2'h3, 1'b0, 10'h3FE), d);
    wr(CTRL, ctl(2'h3, 1'b0, 10'h3FF));
    wait_fr(6);
    `CHK("zf1 hold", 1'b1, zf1);
    wait_fr(5);
    `CHK("zf1 free", 1'b0, zf1);
    wait_fr(40);
    `CHK("att back", 8'h20, att[7:0]);
    @(posedge aclk);
    twm <= 1'b1;
    wr(CTRL, ctl(2'h3, 1'b0, 10'h3FE));
    wait_fr(10);
    wr(CTRL, ctl(2'h3, 1'b0, 10'h3FF));
    wait_fr(40);
    `CHK("no rewrite", 8'h00, att[7:0]);
    wr(CTRL, ctl(2'h3, 1'b0, 10'h3FF));
    wait_fr(40);
    `CHK("rewrite", 8'h20, att[7:0]);
    @(posedge aclk);
    twm <= 1'b0;
    wait_fr(530);
    wr(CTRL, ctl(2'h3, 1'b0, 10'h3FB));
    wait_fr(3);
    `CHK("in hold", 1'b1, serial);
    wait_fr(3);
    `CHK("in off", 1'b0, serial);
    wr(CTRL, ctl(2'h3, 1'b0, 10'h3F3));
    wait_fr(6);
    `CHK("zf out off", 1'b1, zf1);
    `CHK("hiz out off", 4'hF, hiz);
    wr(CTRL, ctl(2'h3, 1'b0, 10'h3AF));
    wait_fr(530);
    `CHK("pair out", 4'hE, out_act);
    `CHK("pair in", 2'h2, in_act);
    wr(CTRL, ctl(2'h3, 1'b0, 10'h3FF));
    wait_fr(20);
    @(posedge aclk);
    nz <= 8'h00;
    wait_fr(8180);
    `CHK("zf1 early", 1'b0, zf1);
    wait_fr(20);
    `CHK("zf1 quiet", 1'b1, zf1);
    @(posedge aclk);
    nz <= 8'h08;
    repeat (2) @(negedge aclk);
    `CHK("zf1 drop", 1'b0, zf1);
    @(posedge aclk);
    pin_n <= 1'b0;
    repeat (3) @(negedge aclk);
    `CHK("att pd", 64'h0, att);
    `CHK("ser pd", 1'b0, serial);
    @(posedge aclk);
    park <= 1'b0;
    repeat (2) @(negedge aclk);
    `CHK("mid pd", 4'h0, out_act | hiz);
    @(posedge aclk);
    pin_n <= 1'b1;
    rd(CTRL);
    `CHK("ctrl pd", 32'h3FF, d);
    report_and_stop();
  end
endmodule : tb
